// *** include/tpcr_defines.vh ***
// Register map, field positions and reset values of the timer prescaler
// and capture readout block. Assumes a 32-bit APB with byte addresses.
`ifndef TPCR_DEFINES_VH
`define TPCR_DEFINES_VH

// Register byte offsets
`define TPCR_OFF_RUN 8'h00
`define TPCR_OFF_CLKCFG 8'h04
`define TPCR_OFF_CAPA 8'h08
`define TPCR_OFF_CAPB 8'h0c
`define TPCR_OFF_STATUS 8'h10

// Run control register fields
`define TPCR_RUN_PRESCALER_BIT 0

// Clock configuration fields
`define TPCR_CFG_PERIPH_SRC_BIT 0
`define TPCR_CFG_LOW_SPEED_BIT 1
`define TPCR_CFG_GEAR_LSB 2
`define TPCR_CFG_GEAR_MSB 4
`define TPCR_CFG_PDIV_LSB 5
`define TPCR_CFG_PDIV_MSB 7
`define TPCR_CFG_WIDTH 8

// Reset values
`define TPCR_RUN_RESET 1'h0
`define TPCR_CFG_RESET 8'h00

// Gear codes
`define TPCR_GEAR_DIV1 3'h0
`define TPCR_GEAR_DIV2 3'h4
`define TPCR_GEAR_DIV4 3'h5
`define TPCR_GEAR_DIV8 3'h6

// Capture field width
`define TPCR_CAP_WIDTH 16

`endif

// *** rtl/tpcr_prescaler.v ***
// 4-bit prescaler producing divide-by-2, 8 and 32 tick enables.
// Assumes inTick is a one-cycle enable on clk, slower than clk.
module tpcr_prescaler #(
  parameter WIDTH = 4
) (
  // Clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // Control
  input wire run,
  input wire inTick,
  // Taps
  output wire tapDiv2,
  output wire tapDiv8,
  output wire tapDiv32,
  output wire [WIDTH:0] countValue
);

  reg halfPhase_reg;
  reg [WIDTH-1:0] count_reg;

  // Half-rate stage feeds the 4-bit counter
  assign tapDiv2 = ce & run & inTick & halfPhase_reg;
  assign tapDiv8 = tapDiv2 & (&count_reg[1:0]);
  assign tapDiv32 = tapDiv2 & (&count_reg);
  assign countValue = {count_reg, halfPhase_reg};

  always @(posedge clk) begin
    if (srst) begin
      halfPhase_reg <= 1'b0;
      count_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
      if (!run) begin
        halfPhase_reg <= 1'b0;
        count_reg <= {WIDTH{1'b0}};
      end else if (inTick) begin
        halfPhase_reg <= ~halfPhase_reg;
        if (halfPhase_reg)
          count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

// *** rtl/tpcr_timer.v ***
// Timer channel prescaler, input clock selection and capture readout.
// Assumes highSpeedTick is a same-domain enable; lowSpeedClock is a pin.
//
// Behaviour
// - Every channel instance is identical apart from its parameters.
// - Capture registers return 16-bit counter value, upper bits zero, read-only.
// - A 4-bit prescaler makes the counting ticks for the up-counter.
// - Prescaler input is low-speed clock or peripheral clock divided 1 to 32.
// - Peripheral clock is the geared clock or the undivided high-speed clock.
// - Run bit 1 starts the prescaler; 0 clears and stops it.
// - Taps give the prescaler input divided by 2, 8 and 32.
// - Divider codes 000-101 give /1../32; gear 000,100,101,110 give /1,2,4,8.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "tpcr_defines.vh"

module tpcr_timer #(
  parameter CAP_WIDTH = `TPCR_CAP_WIDTH
) (
  // Clock, reset, enable
  input wire clk,
  input wire srst,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire [31:0] prdata,
  output wire pslverr,
  // Clock sources
  input wire highSpeedTick,
  input wire lowSpeedClock,
  // Up-counter and capture triggers
  input wire [CAP_WIDTH-1:0] upCounter,
  input wire captureStrobeA,
  input wire captureStrobeB,
  // Counting ticks to the up-counter
  output wire tapDiv2,
  output wire tapDiv8,
  output wire tapDiv32
);

  // True when a divide-by-2^code counter has reached its terminal count
  function divEnd;
    input [4:0] cnt;
    input [2:0] code;
    begin
      case (code)
        3'h0: divEnd = 1'b1;
        3'h1: divEnd = cnt[0];
        3'h2: divEnd = &cnt[1:0];
        3'h3: divEnd = &cnt[2:0];
        3'h4: divEnd = &cnt[3:0];
        3'h5: divEnd = &cnt[4:0];
        default: divEnd = 1'b1;
      endcase
    end
  endfunction

  reg runBit_reg;
  reg [`TPCR_CFG_WIDTH-1:0] clkCfg_reg;
  reg pready_reg;
  reg pslverr_reg;
  reg [31:0] prdata_reg;
  reg [31:0] rdata_next;
  reg mapped_next;
  reg [2:0] gearCnt_reg;
  reg [4:0] pdivCnt_reg;
  reg lowSync1_reg;
  reg lowSync2_reg;
  reg lowPrev_reg;
  reg [2:0] gearCode;
  wire [CAP_WIDTH-1:0] capValue [0:1];
  wire [1:0] capStrobe;
  wire periphSrc;
  wire lowSel;
  wire [2:0] pdivCode;
  wire gearTick;
  wire periphTick;
  wire pdivTick;
  wire lowTick;
  wire prescalerInTick;
  wire [4:0] prescalerCount;
  wire apbDone;
  wire apbWrite;
  wire roAddr;

  assign periphSrc = clkCfg_reg[`TPCR_CFG_PERIPH_SRC_BIT];
  assign lowSel = clkCfg_reg[`TPCR_CFG_LOW_SPEED_BIT];
  assign pdivCode = clkCfg_reg[`TPCR_CFG_PDIV_MSB:`TPCR_CFG_PDIV_LSB];

  // Gear code to divide exponent
  always @* begin
    case (clkCfg_reg[`TPCR_CFG_GEAR_MSB:`TPCR_CFG_GEAR_LSB])
      `TPCR_GEAR_DIV2: gearCode = 3'h1;
      `TPCR_GEAR_DIV4: gearCode = 3'h2;
      `TPCR_GEAR_DIV8: gearCode = 3'h3;
      default: gearCode = 3'h0;
    endcase
  end

  // Geared clock, then peripheral clock and its divider
  assign gearTick = highSpeedTick & divEnd({2'h0, gearCnt_reg}, gearCode);
  assign periphTick = periphSrc ? highSpeedTick : gearTick;
  assign pdivTick = periphTick & divEnd(pdivCnt_reg, pdivCode);
  // Rising edge of the synchronised low-speed pin
  assign lowTick = lowSync2_reg & ~lowPrev_reg;
  assign prescalerInTick = lowSel ? lowTick : pdivTick;

  // Dividers and low-speed clock synchroniser
  always @(posedge clk) begin
    if (srst) begin
      gearCnt_reg <= 3'h0;
      pdivCnt_reg <= 5'h00;
      lowSync1_reg <= 1'b0;
      lowSync2_reg <= 1'b0;
      lowPrev_reg <= 1'b0;
    end else if (ce) begin
      lowSync1_reg <= lowSpeedClock;
      lowSync2_reg <= lowSync1_reg;
      lowPrev_reg <= lowSync2_reg;
      // Cleared while stopped so the first tick after start is full
      if (!runBit_reg) begin
        gearCnt_reg <= 3'h0;
        pdivCnt_reg <= 5'h00;
      end else begin
        if (highSpeedTick)
          gearCnt_reg <= gearCnt_reg + 3'h1;
        if (periphTick)
          pdivCnt_reg <= pdivCnt_reg + 5'h01;
      end
    end
  end

  // Prescaler proper
  tpcr_prescaler #(
    .WIDTH(4)
  ) u_tpcr_prescaler (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .run(runBit_reg),
    .inTick(prescalerInTick),
    .tapDiv2(tapDiv2),
    .tapDiv8(tapDiv8),
    .tapDiv32(tapDiv32),
    .countValue(prescalerCount)
  );

  // Capture registers, identical per slot
  assign capStrobe = {captureStrobeB, captureStrobeA};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : capSlot
      reg [CAP_WIDTH-1:0] capture_reg;
      always @(posedge clk) begin
        if (ce && capStrobe[gi])
          capture_reg <= upCounter;
      end
      assign capValue[gi] = capture_reg;
    end
  endgenerate

  // APB: one wait state, answer registered
  assign apbDone = psel & penable & pready_reg;
  assign apbWrite = apbDone & pwrite & ~pslverr_reg;
  assign pready = pready_reg;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg;

  // Capture and status offsets refuse writes
  assign roAddr = (paddr == `TPCR_OFF_CAPA) | (paddr == `TPCR_OFF_CAPB) |
    (paddr == `TPCR_OFF_STATUS);

  always @* begin
    rdata_next = 32'h00000000;
    mapped_next = 1'b1;
    case (paddr)
      `TPCR_OFF_RUN:
        rdata_next[`TPCR_RUN_PRESCALER_BIT] = runBit_reg;
      `TPCR_OFF_CLKCFG:
        rdata_next[`TPCR_CFG_WIDTH-1:0] = clkCfg_reg;
      `TPCR_OFF_CAPA:
        rdata_next[CAP_WIDTH-1:0] = capValue[0];
      `TPCR_OFF_CAPB:
        rdata_next[CAP_WIDTH-1:0] = capValue[1];
      `TPCR_OFF_STATUS:
        rdata_next[4:0] = prescalerCount;
      default:
        mapped_next = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      runBit_reg <= `TPCR_RUN_RESET;
      clkCfg_reg <= `TPCR_CFG_RESET;
    end else if (ce) begin
      if (psel && penable && !pready_reg) begin
        pready_reg <= 1'b1;
        pslverr_reg <= ~mapped_next | (pwrite & roAddr);
        prdata_reg <= pwrite ? 32'h00000000 : rdata_next;
      end else begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
      // Writes land only at the completing access edge
      if (apbWrite && paddr == `TPCR_OFF_RUN)
        runBit_reg <= pwdata[`TPCR_RUN_PRESCALER_BIT];
      if (apbWrite && paddr == `TPCR_OFF_CLKCFG)
        clkCfg_reg <= pwdata[`TPCR_CFG_WIDTH-1:0];
    end
  end

endmodule

// *** testbench/tpcr_timer_sva.sv ***
// Port checker for the timer prescaler and capture readout.
// Sees only the top module's ports; bound below.
module tpcr_timer_sva (
  // Bus
  input wire clk, srst, ce, psel, penable, pwrite, pready, pslverr,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  // Taps
  input wire tapDiv2, tapDiv8, tapDiv32
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  AST_TAP8_IN_TAP2: assert property (tapDiv8 |-> tapDiv2)
    else $error("tap8 alone");
  AST_TAP32_IN_TAP8: assert property (tapDiv32 |-> tapDiv8)
    else $error("tap32 alone");
  AST_TAP2_PULSE: assert property (tapDiv2 |=> !tapDiv2)
    else $error("tap2 too long");
  AST_TAP8_GAP: assert property (tapDiv8 |=> !tapDiv8 [*7])
    else $error("tap8 too soon");
  AST_READY_WAIT: assert property (psel && penable && ce && !pready
    |=> pready) else $error("pready late");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_CAP_RO: assert property (pready && pwrite
    && (paddr == 8'h08 || paddr == 8'h0c) |-> pslverr)
    else $error("capture write taken");
  AST_CAP_UPPER: assert property (pready && !pwrite
    && (paddr == 8'h08 || paddr == 8'h0c) |-> prdata[31:16] == 16'h0)
    else $error("capture upper bits");
endmodule

bind tpcr_timer tpcr_timer_sva u_sva (.clk(clk), .srst(srst), .ce(ce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
  .pslverr(pslverr), .paddr(paddr), .prdata(prdata), .tapDiv2(tapDiv2),
  .tapDiv8(tapDiv8), .tapDiv32(tapDiv32));

// *** testbench/tpcr_timer_tb.sv ***
// Self-checking bench for the timer prescaler and capture readout.
// Drives APB, clock sources and capture strobes itself.
module tpcr_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic ce = 1, hsTick = 1, lsClk = 0, capA = 0, capB = 0, err;
  logic pready, pslverr, tap2, tap8, tap32;
  logic [7:0] paddr = 8'h00, c;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [15:0] upCnt = 16'h0, va, vb;
  logic [2:0] gears [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
  int n_mismatch = 0, checks_done = 0, lsCnt = 0, per;
  int hsGap = 1, hsCnt = 0;
  tpcr_timer u_tpcr_timer (.clk(clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .highSpeedTick(hsTick), .lowSpeedClock(lsClk), .upCounter(upCnt),
    .captureStrobeA(capA), .captureStrobeB(capB), .tapDiv2(tap2),
    .tapDiv8(tap8), .tapDiv32(tap32));
  initial forever #20 clk = ~clk;
  // Low-speed pin rises every 10 cycles
  always @(posedge clk) begin
    lsCnt <= (lsCnt == 4) ? 0 : lsCnt + 1;
    if (lsCnt == 4) lsClk <= ~lsClk;
  end
  // High-speed tick: one cycle in every hsGap
  always @(posedge clk) begin
    hsCnt <= (hsCnt >= hsGap - 1) ? 0 : hsCnt + 1;
    hsTick <= (hsCnt >= hsGap - 1);
  end
  task automatic chkV(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t read %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkN(input int got, exp);
    checks_done++;
    if (got != exp) begin
      n_mismatch++;
      $display("ERROR %0t period %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    // Request held until pready is seen; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  function automatic int expPer(input logic [7:0] k);
    int g;
    if (k[1]) return 20;
    g = k[0] ? 1 : (k[4:2] == 3'h4) ? 2 : (k[4:2] == 3'h5) ? 4 :
      (k[4:2] == 3'h6) ? 8 : 1;
    return 2 * g * ((k[7:5] > 3'h5) ? 1 : (1 << k[7:5]));
  endfunction
  function automatic logic tapOf(input int k);
    return k == 0 ? tap2 : k == 1 ? tap8 : tap32;
  endfunction
  task automatic period(input int k);
    int t = 0;
    per = 0;
    do begin
      @(negedge clk);
      t++;
    end while (tapOf(k) !== 1'b1 && t < 3000);
    do begin
      @(negedge clk);
      per++;
    end while (tapOf(k) !== 1'b1 && per < 3000);
  endtask
  task automatic cfgRun(input logic [7:0] k);
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h04, {24'h0, k});
    apb(1, 8'h00, 32'h1);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    n_mismatch++;
    conclude;
  end
  initial begin
    void'($urandom(62));
    repeat (6) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    apb(0, 8'h04, 0);
    chkV(rd, 32'h0);
    apb(0, 8'h00, 0);
    chkV(rd, 32'h0);
    va = $urandom;
    vb = $urandom;
    upCnt <= va;
    capA <= 1;
    @(posedge clk);
    upCnt <= vb;
    capA <= 0;
    capB <= 1;
    @(posedge clk);
    capB <= 0;
    upCnt <= ~vb;
    apb(1, 8'h08, 32'hffff_ffff);
    chkV({31'h0, err}, 32'h1);
    apb(0, 8'h08, 0);
    chkV(rd, {16'h0, va});
    apb(0, 8'h0c, 0);
    chkV(rd, {16'h0, vb});
    apb(0, 8'h14, 0);
    chkV({rd[30:0], err}, 32'h1);
    // Every divider code, random gear and source, then two corners
    for (int i = 0; i < 10; i++) begin
      c = {i[2:0], gears[$urandom % 4], 1'b0, 1'($urandom % 2)};
      hsGap = 1 + $urandom % 2;
      if (i == 8) c = 8'h19;
      if (i == 9) c = 8'hb8;
      cfgRun(c);
      period(0);
      chkN(per, hsGap * expPer(c));
    end
    hsGap = 1;
    cfgRun(8'h01);
    period(1);
    chkN(per, 8);
    period(2);
    chkN(per, 32);
    // Clock enable low for five edges stretches one period by five
    @(posedge clk);
    ce <= 0;
    repeat (5) @(posedge clk);
    ce <= 1;
    per = 5;
    do begin
      @(negedge clk);
      per++;
    end while (tap32 !== 1'b1 && per < 3000);
    chkN(per, 37);
    cfgRun(8'h02);
    period(0);
    chkN(per, 20);
    apb(1, 8'h00, 32'h0);
    period(0);
    chkN(per, 3000);
    conclude;
  end
endmodule
